//--- dps_pkg.sv
`default_nettype none
package dps_pkg;
   // clock rate used to turn times into cycle counts
   localparam int unsigned CLK_HZ = 100_000_000;
   // soft-start phase length: 1 ms per phase
   localparam int unsigned PHASE_TIME_US = 1000;
   localparam int unsigned PHASE_CYCLES = (CLK_HZ / 1_000_000) * PHASE_TIME_US;
   // full current limit applies after this many cycles at the latest
   localparam int unsigned FULL_LIMIT_CYCLES = 3072;
   // each pump ramp lasts this many cycles
   localparam int unsigned PUMP_RAMP_CYCLES = 4096;
   localparam int unsigned CNT_W = 17;
   localparam int unsigned RAMP_W = 12;

   // current-limit phase codes (quarter steps of the full 1.5 A limit)
   localparam logic [1:0] ILIM_QUARTER = 2'h0;
   localparam logic [1:0] ILIM_HALF = 2'h1;
   localparam logic [1:0] ILIM_3QUARTER = 2'h2;
   localparam logic [1:0] ILIM_FULL = 2'h3;

   // AHB-Lite register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // ctrl bit: board has no charge pumps (pure delay sequence)
   localparam int unsigned CTRL_NO_PUMPS = 0;
   localparam logic CTRL_RESET = 1'b0;
   // interrupt events
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_READY = 0;
   localparam int unsigned IRQ_FAULT = 1;
   localparam int unsigned IRQ_SEQ_STEP = 2;

   typedef enum logic [2:0] {
      DPS_OFF = 3'b000,
      DPS_REF = 3'b001,
      DPS_MAIN = 3'b010,
      DPS_NEG = 3'b011,
      DPS_POS = 3'b100,
      DPS_READY = 3'b101,
      DPS_FAULT = 3'b110
   } dps_state_t;

   // comparator inputs, already sampled on the oscillator clock
   typedef struct packed {
      logic main_reg;
      logic neg_fb_below_110mv;
      logic pos_fb_above_1125mv;
      logic main_under;
      logic neg_fb_above_140mv;
      logic pos_under;
      logic in_uvlo;
      logic over_temp;
   } dps_sense_t;

   // enables driven out to the analog blocks
   typedef struct packed {
      logic ref_en;
      logic ref_gnd;
      logic main_en;
      logic soft_start;
      logic ldo_en;
      logic neg_pump_en;
      logic pos_pump_en;
      logic backplane_buffer_en;
   } dps_enables_t;
endpackage
`default_nettype wire

//--- dps_sequencer.sv
// Added by the designer: the address map and the AHB-Lite slave port.
`default_nettype none
module dps_sequencer
   import dps_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic power_off_request_n,
   input wire dps_sense_t sense,
   output dps_enables_t enables,
   output logic [1:0] ilim_phase,
   output logic [RAMP_W-1:0] pump_ramp,
   output logic pump_drive,
   output logic ready_n_out,
   output logic ready_n_oe,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // bus slave state
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   logic ctrl_no_pumps, next_ctrl_no_pumps;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [IRQ_W-1:0] irq_mask, next_irq_mask;

   // sequencer state
   dps_state_t state, next_state;
   logic [CNT_W-1:0] phase_cnt, next_phase_cnt;
   logic [CNT_W-1:0] ss_cnt, next_ss_cnt;
   logic [1:0] next_ilim_phase;
   logic [RAMP_W-1:0] next_pump_ramp;
   logic ramp_done, next_ramp_done;
   logic main_reg_seen, next_main_reg_seen;
   logic main_reg_q, next_main_reg_q;
   logic power_off_request_n_q, next_power_off_request_n_q;
   logic pump_drive_q, next_pump_drive;
   logic [IRQ_W-1:0] events;
   logic fault_cond;
   logic power_off_request_n_edge;
   logic bus_rd, bus_wr;

   assign bus_rd = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
   assign bus_wr = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;

   ////////////////////////////////////////////////////////////////////////
   // fault sources; only looked at once power-good is asserted
   assign fault_cond = sense.main_under | sense.pos_under |
                       sense.neg_fb_above_140mv | sense.in_uvlo;
   // a level change either way on power-off request
   assign power_off_request_n_edge = power_off_request_n_q ^ power_off_request_n;

   // sequencer next-state
   always_comb begin
      next_state = state;
      next_phase_cnt = phase_cnt;
      next_ss_cnt = ss_cnt;
      next_ilim_phase = ilim_phase;
      next_pump_ramp = pump_ramp;
      next_ramp_done = ramp_done;
      next_main_reg_seen = main_reg_seen;
      next_main_reg_q = sense.main_reg;
      next_power_off_request_n_q = power_off_request_n;
      next_pump_drive = pump_drive_q;
      events = '0;
      // ramp counter runs while a pump step is active
      if (state == DPS_NEG || state == DPS_POS) begin
         if (pump_ramp == RAMP_W'(PUMP_RAMP_CYCLES - 1)) begin
            next_ramp_done = 1'b1;
         end else begin
            next_pump_ramp = pump_ramp + RAMP_W'(1);
         end
      end
      if (!power_off_request_n) begin
         next_state = DPS_OFF;
         next_pump_drive = 1'b0;
      end else if (sense.over_temp && state != DPS_FAULT
                   && state != DPS_OFF) begin
         next_state = DPS_FAULT;
         events[IRQ_FAULT] = 1'b1;
      end else begin
         case (state)
            DPS_OFF: begin
               next_state = DPS_REF;
               next_ilim_phase = ILIM_QUARTER;
               next_phase_cnt = '0;
               next_ss_cnt = '0;
               next_main_reg_seen = 1'b0;
               next_pump_ramp = '0;
               next_ramp_done = 1'b0;
            end
            DPS_REF: begin
               next_state = DPS_MAIN;
               events[IRQ_SEQ_STEP] = 1'b1;
            end
            DPS_MAIN: begin
               next_ss_cnt = ss_cnt + CNT_W'(1);
               next_phase_cnt = phase_cnt + CNT_W'(1);
               if (sense.main_reg != main_reg_q) begin
                  next_main_reg_seen = 1'b1;
               end
               if (sense.main_reg || main_reg_seen
                   || ss_cnt >= CNT_W'(FULL_LIMIT_CYCLES - 1)) begin
                  next_ilim_phase = ILIM_FULL;
               end else if (phase_cnt == CNT_W'(PHASE_CYCLES - 1)) begin
                  next_phase_cnt = '0;
                  if (ilim_phase != ILIM_FULL) begin
                     next_ilim_phase = ilim_phase + 2'h1;
                  end
               end
               // first comparator change starts the negative pump
               if (sense.main_reg != main_reg_q || main_reg_seen) begin
                  next_state = DPS_NEG;
                  next_ilim_phase = ILIM_FULL;
                  next_pump_ramp = '0;
                  next_ramp_done = 1'b0;
                  events[IRQ_SEQ_STEP] = 1'b1;
               end
            end
            DPS_NEG: begin
               next_pump_drive = ~pump_drive_q;
               if (ctrl_no_pumps ? ramp_done
                   : sense.neg_fb_below_110mv) begin
                  next_state = DPS_POS;
                  next_pump_ramp = '0;
                  next_ramp_done = 1'b0;
                  events[IRQ_SEQ_STEP] = 1'b1;
               end
            end
            DPS_POS: begin
               next_pump_drive = ~pump_drive_q;
               if (ctrl_no_pumps ? ramp_done
                   : sense.pos_fb_above_1125mv) begin
                  next_state = DPS_READY;
                  events[IRQ_READY] = 1'b1;
               end
            end
            DPS_READY: begin
               next_pump_drive = ~pump_drive_q;
               if (fault_cond) begin
                  next_state = DPS_FAULT;
                  events[IRQ_FAULT] = 1'b1;
               end
            end
            DPS_FAULT: begin
               next_pump_drive = 1'b0;
               // latch holds until power-off request changes level
               if (power_off_request_n_edge) begin
                  next_state = DPS_OFF;
               end
            end
            default: begin
               next_state = DPS_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= DPS_OFF;
         phase_cnt <= '0;
         ss_cnt <= '0;
         ilim_phase <= ILIM_QUARTER;
         pump_ramp <= '0;
         ramp_done <= 1'b0;
         main_reg_seen <= 1'b0;
         main_reg_q <= 1'b0;
         power_off_request_n_q <= 1'b0;
         pump_drive_q <= 1'b0;
      end else begin
         state <= next_state;
         phase_cnt <= next_phase_cnt;
         ss_cnt <= next_ss_cnt;
         ilim_phase <= next_ilim_phase;
         pump_ramp <= next_pump_ramp;
         ramp_done <= next_ramp_done;
         main_reg_seen <= next_main_reg_seen;
         main_reg_q <= next_main_reg_q;
         power_off_request_n_q <= next_power_off_request_n_q;
         pump_drive_q <= next_pump_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // enables decoded from state; regulator status is never an input here
   always_comb begin
      enables = '0;
      enables.ref_gnd = (state == DPS_OFF);
      enables.ref_en = (state != DPS_OFF);
      enables.main_en = (state == DPS_MAIN) || (state == DPS_NEG)
                        || (state == DPS_POS) || (state == DPS_READY);
      enables.ldo_en = enables.main_en;
      enables.soft_start = (state == DPS_MAIN);
      enables.neg_pump_en = (state == DPS_NEG) || (state == DPS_POS)
                            || (state == DPS_READY);
      enables.pos_pump_en = (state == DPS_POS) || (state == DPS_READY);
      enables.backplane_buffer_en = (state == DPS_READY);
   end

   assign pump_drive = pump_drive_q;
   // open drain: pull low only while ready
   assign ready_n_out = 1'b0;
   assign ready_n_oe = (state == DPS_READY);

   ////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, writes land in the data phase
   always_comb begin
      next_wr_pend = bus_wr;
      next_wr_addr = bus_wr ? haddr[7:0] : wr_addr;
      next_ctrl_no_pumps = ctrl_no_pumps;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      // read data holds until the next read so the master's sampling edge
      // never races the register update
      next_hrdata = hrdata;
      if (wr_pend) begin
         case (wr_addr)
            ADDR_CTRL: next_ctrl_no_pumps = hwdata[CTRL_NO_PUMPS];
            ADDR_IRQ_MASK: next_irq_mask = hwdata[IRQ_W-1:0];
            ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      next_irq_stat = next_irq_stat | events;
      if (bus_rd) begin
         case (haddr[7:0])
            ADDR_CTRL: next_hrdata = {31'h0, ctrl_no_pumps};
            ADDR_STATUS: next_hrdata = {21'h0, ilim_phase, state,
                                        enables.ref_en, enables.main_en,
                                        enables.neg_pump_en,
                                        enables.pos_pump_en,
                                        enables.backplane_buffer_en,
                                        state == DPS_FAULT};
            ADDR_IRQ_STAT: next_hrdata = {29'h0, irq_stat};
            ADDR_IRQ_MASK: next_hrdata = {29'h0, irq_mask};
            default: next_hrdata = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         ctrl_no_pumps <= CTRL_RESET;
         irq_mask <= '0;
         irq_stat <= '0;
         hrdata <= '0;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         ctrl_no_pumps <= next_ctrl_no_pumps;
         irq_mask <= next_irq_mask;
         irq_stat <= next_irq_stat;
         hrdata <= next_hrdata;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

//--- dps_sequencer_bench.sv
`default_nettype none
module dps_sequencer_bench
   import dps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] flt;
      logic [7:0] en;
   } dps_row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic pwr_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   dps_sense_t sense = '0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, pump_drive, ready_n_out, ready_n_oe, irq, p;
   dps_enables_t enables;
   logic [1:0] ilim_phase;
   logic [RAMP_W-1:0] pump_ramp;
   int miscompares = 0;
   int n_compared = 0;
   // each fault source alone must leave only the reference running
   dps_row_t rows [5] = '{'{8'h10, 8'h80}, '{8'h08, 8'h80},
      '{8'h04, 8'h80}, '{8'h02, 8'h80}, '{8'h01, 8'h80}};

   ////////////////////////////////////////////////////////////////////////
   // free-running oscillator clock
   always #5 hclk = ~hclk;

   dps_sequencer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .power_off_request_n(pwr_n), .sense, .enables, .ilim_phase,
      .pump_ramp, .pump_drive, .ready_n_out, .ready_n_oe, .irq);

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // one single transfer; the slave never stalls but we still wait on it
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // checks land mid-cycle so the edge's updates have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask

   task automatic give_verdict;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // from off through main start to the negative pump step
   task automatic up(input logic pumped);
      @(posedge hclk);
      sense <= '0;
      pwr_n <= 1'b1;
      cyc(2);
      chk("main", 32'hb8, enables);
      chk("ilim", ILIM_QUARTER, ilim_phase);
      @(posedge hclk);
      sense.main_reg <= 1'b1;
      cyc(1);
      if (pumped) chk("neg", 1, enables.neg_pump_en);
      chk("ilim", ILIM_FULL, ilim_phase);
   endtask

   // pump steps up to power-good; ready and step events are masked
   task automatic pumps;
      p = pump_drive;
      cyc(1);
      chk("drive", !p, pump_drive);
      @(posedge hclk);
      sense.neg_fb_below_110mv <= 1'b1;
      cyc(1);
      chk("pos", 1, enables.pos_pump_en);
      @(posedge hclk);
      sense.pos_fb_above_1125mv <= 1'b1;
      cyc(1);
      chk("ready", 3'h7, {ready_n_oe, enables.backplane_buffer_en, !irq});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(1);
      chk("reset", 32'h40, {ready_n_oe, irq, enables});
      // every register plus one unmapped word reads zero after reset
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 8'(i * 4), 32'h0);
         chk("regs", 32'h0, rd);
      end
      bus(1'b1, ADDR_IRQ_MASK, 32'(1 << IRQ_FAULT));
      foreach (rows[i]) begin
         up(1'b1);
         pumps();
         @(posedge hclk);
         sense <= sense | rows[i].flt;
         cyc(1);
         chk("fault", rows[i].en, enables);
         bus(1'b0, ADDR_STATUS, 32'h0);
         chk("status", 9'h1a1, rd[8:0]);
         chk("irq", 1, irq);
         bus(1'b1, ADDR_IRQ_STAT, 32'h7);
         cyc(1);
         chk("irq", 0, irq);
         @(posedge hclk);
         pwr_n <= 1'b0;
         cyc(1);
         chk("clear", 32'h40, enables);
      end
      // no regulation: phases are far longer than the cycle cap
      @(posedge hclk);
      sense <= '0;
      pwr_n <= 1'b1;
      cyc(3000);
      chk("ilim", ILIM_QUARTER, ilim_phase);
      cyc(80);
      chk("ilim", ILIM_FULL, ilim_phase);
      @(posedge hclk);
      sense.over_temp <= 1'b1;
      cyc(1);
      chk("hot", 32'h80, enables);
      @(posedge hclk);
      sense <= '0;
      pwr_n <= 1'b0;
      // pumpless board: two fixed ramps stand in for the pump steps
      bus(1'b1, ADDR_CTRL, 32'h1);
      up(1'b0);
      cyc(8100);
      chk("nopump", 0, ready_n_oe);
      for (int i = 0; i < 300 && ready_n_oe !== 1'b1; i++) cyc(1);
      chk("nopump", 1, ready_n_oe);
      @(posedge hclk);
      pwr_n <= 1'b0;
      cyc(1);
      chk("off", 32'h40, enables);
      give_verdict();
   end

   // the whole run needs about 11400 cycles; allow three and a half times that
   initial begin
      #400_000;
      miscompares++;
      give_verdict();
   end
endmodule
`default_nettype wire

//--- dps_sequencer_sva.sv
`default_nettype none
module dps_sequencer_sva
   import dps_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic power_off_request_n,
   input wire dps_sense_t sense,
   input wire dps_enables_t enables,
   input wire logic [1:0] ilim_phase,
   input wire logic pump_drive,
   input wire logic ready_n_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic fault_in;
   logic run;

   // undervoltage faults only count once power-good is out
   assign fault_in = sense.main_under | sense.neg_fb_above_140mv |
                     sense.pos_under | sense.in_uvlo;
   // a power-off overrides every sequencing step, a heat event every step but the one out of off
   assign run = power_off_request_n & ~sense.over_temp;

   ////////////////////////////////////////////////////////////////////////
   a_off_all_dark: assert property (
      !power_off_request_n |=> enables == 8'h40)
      else $error("outputs not dark after power-off request");
   a_main_with_ldo: assert property (
      enables.main_en |-> enables.ref_en && enables.ldo_en)
      else $error("main converter on without reference or regulator");
   a_pump_toggles: assert property (
      enables.neg_pump_en && $past(enables.neg_pump_en)
      |-> pump_drive != $past(pump_drive))
      else $error("pump drive missed a toggle");
   a_edge_starts_neg: assert property (
      enables.main_en && !enables.neg_pump_en && run &&
      sense.main_reg != $past(sense.main_reg) |=> enables.neg_pump_en)
      else $error("negative pump not started on regulation edge");
   a_neg_starts_pos: assert property (
      enables.neg_pump_en && !enables.pos_pump_en && run &&
      sense.neg_fb_below_110mv |=> enables.pos_pump_en)
      else $error("positive pump not started");
   a_pos_gives_ready: assert property (
      enables.pos_pump_en && !ready_n_oe && run &&
      sense.pos_fb_above_1125mv |=> ready_n_oe && enables.backplane_buffer_en)
      else $error("power-good or buffer not raised");
   a_start_quarter: assert property (
      $rose(enables.main_en) |-> ilim_phase == ILIM_QUARTER)
      else $error("soft-start not begun at quarter limit");
   a_full_on_reg: assert property (
      enables.main_en && sense.main_reg && run && !fault_in
      |=> ilim_phase == ILIM_FULL)
      else $error("full limit not applied at regulation");
   a_fault_latches: assert property (
      ready_n_oe && fault_in && power_off_request_n
      |=> !ready_n_oe && enables == 8'h80)
      else $error("fault did not drop outputs and keep reference");
   a_hot_shutdown: assert property (
      enables.main_en && sense.over_temp && power_off_request_n
      |=> enables == 8'h80)
      else $error("over-temperature did not latch the fault");
endmodule

bind dps_sequencer dps_sequencer_sva u_sva (.hclk, .hresetn,
   .power_off_request_n, .sense, .enables, .ilim_phase, .pump_drive,
   .ready_n_oe);
`default_nettype wire
